// ---- core_model.sv ----
// Core model issuing one ALU operation and instruction event per request
`timescale 1ns/1ps
module core_model (
  input wire clk_i,
  input wire go_i,
  input wire [21:0] cmd_i,
  output logic [2:0] op_o = 3'h0,
  output logic [7:0] a_o = 8'h00,
  output logic [7:0] b_o = 8'h00,
  output logic [2:0] ev_o = 3'h0
);
  // Idle operands toggle so no stale value looks valid
  always @(posedge clk_i) begin
    {op_o, a_o, b_o, ev_o} <= go_i ? cmd_i : {3'h0, ~a_o, ~b_o, 3'h0};
  end
endmodule

// ---- core_regs_map.vh ----
// Register map, field positions and reset values of the core status and interrupt registers
// Behaviour
// - Status bit 7 selects indirect bank pair
// - Status bits 6-5 select direct bank
// - Timeout flag set by power-up/clear/sleep, cleared by timeout
// - Power-down flag set by power-up/clear, cleared by sleep
// - Flags not writable; ALU flag writes suppressed
// - Zero flag follows result equals zero
// - Digit carry from bit 3, inverted borrow
// - Carry from bit 7, inverted borrow
// - Subtract adds two's complement of operand
// - Rotates load carry with bit shifted out
// - Global enable gates every interrupt
// - Peripheral enable gates peripheral interrupts
// - Bit 5 enables timer overflow interrupt
// - Bit 4 enables external pin interrupt
// - External flag set on edge, software clears
// - Change flag set on upper port B change
// - Flags set regardless of enables
`ifndef CORE_REGS_MAP_VH
`define CORE_REGS_MAP_VH
`define ADDR_CORE_STATUS 8'h03
`define ADDR_INTERRUPT_CONTROL 8'h0b
`define ADDR_TIMER_PRESCALE_OPTIONS 8'h81
`define ST_IRP 7
`define ST_RP_HI 6
`define ST_RP_LO 5
`define ST_TO 4
`define ST_PD 3
`define ST_Z 2
`define ST_DC 1
`define ST_C 0
`define OPT_PORTB_PULLUP_DISABLE 7
`define OPT_EXT_INT_EDGE 6
`define OPT_TIMER0_SOURCE_SELECT 5
`define OPT_TIMER0_EDGE_SELECT 4
`define OPT_PSA 3
`define IC_GIE 7
`define IC_PERIPH_INT_ENABLE 6
`define IC_TIMER0_OVF_INT_ENABLE 5
`define IC_EXT_INT_ENABLE 4
`define IC_PORTB_CHANGE_INT_ENABLE 3
`define IC_TIMER0_OVF_FLAG 2
`define IC_EXT_INT_FLAG 1
`define IC_PORTB_CHANGE_FLAG 0
`define STATUS_RESET 8'h18
`define OPTION_RESET 8'hff
`define INTERRUPT_CONTROL_RESET 8'h00
`define OP_NONE 3'h0
`define OP_ADD 3'h1
`define OP_SUB 3'h2
`define OP_LOGIC 3'h3
`define OP_RLF 3'h4
`define OP_RRF 3'h5
`endif

// ---- core_status_interrupt_regs.v ----
// Core status, option and interrupt control registers with flag logic and Wishbone slave
//
// Our own choice: the Wishbone interface to the registers.
`timescale 1ns/1ps
`include "core_regs_map.vh"
module core_status_interrupt_regs (
  input wire clk_i,
  input wire rst_i,
  input wire cyc_i,
  input wire stb_i,
  input wire we_i,
  input wire [7:0] adr_i,
  input wire [7:0] dat_i,
  input wire sel_i,
  output reg [7:0] dat_o,
  output reg ack_o,
  input wire [2:0] alu_op_i,
  input wire [7:0] alu_a_i,
  input wire [7:0] alu_b_i,
  input wire alu_dest_status_i,
  output reg [7:0] alu_result_o,
  input wire clear_watchdog_instr_i,
  input wire sleep_instr_i,
  input wire watchdog_timeout_i,
  input wire [6:0] direct_addr_i,
  input wire [7:0] indirect_addr_i,
  output reg [8:0] direct_full_addr_o,
  output reg [8:0] indirect_full_addr_o,
  input wire timer0_overflow_i,
  input wire ext_int_pin_i,
  input wire [3:0] portb_upper_pins_i,
  input wire periph_int_req_i,
  input wire watchdog_tick_i,
  input wire timer0_clock_pin_i,
  input wire instr_cycle_tick_i,
  output reg timer0_tick_o,
  output reg watchdog_tick_o,
  output reg portb_pullup_enable_o,
  output reg int_request_o
);
  reg [7:0] core_status_reg;
  reg [7:0] timer_prescale_options_reg;
  reg [7:0] interrupt_control_reg;
  reg [7:0] prescaler_reg;
  reg [1:0] ext_sync_reg;
  reg ext_prev_reg;
  reg [3:0] pb_s1_reg;
  reg [3:0] pb_s2_reg;
  reg [3:0] pb_prev_reg;
  reg [1:0] t0ck_sync_reg;
  reg t0ck_prev_reg;
  reg [7:0] status_next;
  reg [7:0] interrupt_control_next;
  reg [8:0] sum;
  reg [4:0] nib;
  reg [7:0] result;
  reg zero_upd;
  reg carry_upd;
  reg dc_upd;
  reg carry_val;
  reg dc_val;
  reg ext_edge;
  reg t0_src_tick;
  reg pre_tap;
  reg pre_src;

  wire bus_req = cyc_i & stb_i & ~ack_o;
  wire bus_wr = bus_req & we_i & sel_i;
  wire wr_status = bus_wr && adr_i == `ADDR_CORE_STATUS;
  wire wr_interrupt_control = bus_wr && adr_i == `ADDR_INTERRUPT_CONTROL;
  wire wr_option = bus_wr && adr_i == `ADDR_TIMER_PRESCALE_OPTIONS;
  wire [2:0] prescaler_rate = timer_prescale_options_reg[2:0];
  wire prescaler_assign = timer_prescale_options_reg[`OPT_PSA];
  wire pb_change = |(pb_s2_reg ^ pb_prev_reg);

  // Low-bit mask of the prescaler count for a divide by two to the power sh
  function [7:0] rate_mask;
    input [3:0] sh;
    begin
      rate_mask = (8'h01 << sh) - 8'h01;
    end
  endfunction

  // ALU with flag generation
  always @* begin
    sum = 9'h000;
    nib = 5'h00;
    result = 8'h00;
    zero_upd = 1'b0;
    carry_upd = 1'b0;
    dc_upd = 1'b0;
    carry_val = 1'b0;
    dc_val = 1'b0;
    case (alu_op_i)
      `OP_ADD: begin
        sum = {1'b0, alu_a_i} + {1'b0, alu_b_i};
        nib = {1'b0, alu_a_i[3:0]} + {1'b0, alu_b_i[3:0]};
        result = sum[7:0];
        zero_upd = 1'b1;
        carry_upd = 1'b1;
        dc_upd = 1'b1;
        carry_val = sum[8];
        dc_val = nib[4];
      end
      `OP_SUB: begin
        // a + ~b + 1 so carries act as inverted borrows
        sum = {1'b0, alu_a_i} + {1'b0, ~alu_b_i} + 9'h001;
        nib = {1'b0, alu_a_i[3:0]} + {1'b0, ~alu_b_i[3:0]} + 5'h01;
        result = sum[7:0];
        zero_upd = 1'b1;
        carry_upd = 1'b1;
        dc_upd = 1'b1;
        carry_val = sum[8];
        dc_val = nib[4];
      end
      `OP_LOGIC: begin
        result = alu_a_i;
        zero_upd = 1'b1;
      end
      `OP_RLF: begin
        result = {alu_a_i[6:0], core_status_reg[`ST_C]};
        carry_upd = 1'b1;
        carry_val = alu_a_i[7];
      end
      `OP_RRF: begin
        result = {core_status_reg[`ST_C], alu_a_i[7:1]};
        carry_upd = 1'b1;
        carry_val = alu_a_i[0];
      end
      default: begin
        result = alu_a_i;
      end
    endcase
  end

  // Status register next value
  always @* begin
    status_next = core_status_reg;
    if (wr_status) begin
      status_next[7:5] = dat_i[7:5];
      // Software write of the ALU flags is blocked while the ALU updates them
      if (!(alu_dest_status_i && zero_upd)) status_next[`ST_Z] = dat_i[`ST_Z];
      if (!(alu_dest_status_i && dc_upd)) status_next[`ST_DC] = dat_i[`ST_DC];
      if (!(alu_dest_status_i && carry_upd)) status_next[`ST_C] = dat_i[`ST_C];
    end
    if (zero_upd) status_next[`ST_Z] = (result == 8'h00);
    if (dc_upd) status_next[`ST_DC] = dc_val;
    if (carry_upd) status_next[`ST_C] = carry_val;
    if (clear_watchdog_instr_i) begin
      status_next[`ST_TO] = 1'b1;
      status_next[`ST_PD] = 1'b1;
    end else if (sleep_instr_i) begin
      status_next[`ST_TO] = 1'b1;
      status_next[`ST_PD] = 1'b0;
    end
    if (watchdog_timeout_i) status_next[`ST_TO] = 1'b0;
  end

  // Edge detection on the synchronised external pin
  always @* begin
    if (timer_prescale_options_reg[`OPT_EXT_INT_EDGE]) begin
      ext_edge = ext_sync_reg[1] & ~ext_prev_reg;
    end else begin
      ext_edge = ~ext_sync_reg[1] & ext_prev_reg;
    end
  end

  // Interrupt control next value: hardware set wins over software clear
  always @* begin
    interrupt_control_next = interrupt_control_reg;
    if (wr_interrupt_control) interrupt_control_next = dat_i;
    if (timer0_overflow_i) interrupt_control_next[`IC_TIMER0_OVF_FLAG] = 1'b1;
    if (ext_edge) interrupt_control_next[`IC_EXT_INT_FLAG] = 1'b1;
    if (pb_change) interrupt_control_next[`IC_PORTB_CHANGE_FLAG] = 1'b1;
  end

  // Timer0 source and prescaler routing
  always @* begin
    if (timer_prescale_options_reg[`OPT_TIMER0_SOURCE_SELECT]) begin
      if (timer_prescale_options_reg[`OPT_TIMER0_EDGE_SELECT]) begin
        t0_src_tick = ~t0ck_sync_reg[1] & t0ck_prev_reg;
      end else begin
        t0_src_tick = t0ck_sync_reg[1] & ~t0ck_prev_reg;
      end
    end else begin
      t0_src_tick = instr_cycle_tick_i;
    end
    pre_src = prescaler_assign ? watchdog_tick_i : t0_src_tick;
    // Timer path taps one stage further: 000 is 1:2, watchdog 000 is 1:1
    if (prescaler_assign) begin
      pre_tap = pre_src && ((prescaler_reg & rate_mask({1'b0, prescaler_rate})) ==
        rate_mask({1'b0, prescaler_rate}));
    end else begin
      pre_tap = pre_src && ((prescaler_reg & rate_mask({1'b0, prescaler_rate} + 4'h1)) ==
        rate_mask({1'b0, prescaler_rate} + 4'h1));
    end
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      core_status_reg <= `STATUS_RESET;
      timer_prescale_options_reg <= `OPTION_RESET;
      interrupt_control_reg <= `INTERRUPT_CONTROL_RESET;
      prescaler_reg <= 8'h00;
      ext_sync_reg <= 2'b00;
      ext_prev_reg <= 1'b0;
      pb_s1_reg <= 4'h0;
      pb_s2_reg <= 4'h0;
      pb_prev_reg <= 4'h0;
      t0ck_sync_reg <= 2'b00;
      t0ck_prev_reg <= 1'b0;
      dat_o <= 8'h00;
      ack_o <= 1'b0;
      alu_result_o <= 8'h00;
      direct_full_addr_o <= 9'h000;
      indirect_full_addr_o <= 9'h000;
      timer0_tick_o <= 1'b0;
      watchdog_tick_o <= 1'b0;
      portb_pullup_enable_o <= 1'b0;
      int_request_o <= 1'b0;
    end else begin
      core_status_reg <= status_next;
      interrupt_control_reg <= interrupt_control_next;
      if (wr_option) timer_prescale_options_reg <= dat_i;
      ext_sync_reg <= {ext_sync_reg[0], ext_int_pin_i};
      ext_prev_reg <= ext_sync_reg[1];
      pb_s1_reg <= portb_upper_pins_i;
      pb_s2_reg <= pb_s1_reg;
      pb_prev_reg <= pb_s2_reg;
      t0ck_sync_reg <= {t0ck_sync_reg[0], timer0_clock_pin_i};
      t0ck_prev_reg <= t0ck_sync_reg[1];
      if (pre_src) prescaler_reg <= prescaler_reg + 8'h01;
      if (wr_option && dat_i[`OPT_PSA] != prescaler_assign) prescaler_reg <= 8'h00;
      timer0_tick_o <= prescaler_assign ? t0_src_tick : pre_tap;
      watchdog_tick_o <= prescaler_assign ? pre_tap : watchdog_tick_i;
      alu_result_o <= result;
      direct_full_addr_o <= {core_status_reg[`ST_RP_HI:`ST_RP_LO], direct_addr_i};
      indirect_full_addr_o <= {core_status_reg[`ST_IRP], indirect_addr_i};
      portb_pullup_enable_o <= ~timer_prescale_options_reg[`OPT_PORTB_PULLUP_DISABLE];
      int_request_o <= interrupt_control_reg[`IC_GIE] & (
        (interrupt_control_reg[`IC_TIMER0_OVF_INT_ENABLE] & interrupt_control_reg[`IC_TIMER0_OVF_FLAG]) |
        (interrupt_control_reg[`IC_EXT_INT_ENABLE] & interrupt_control_reg[`IC_EXT_INT_FLAG]) |
        (interrupt_control_reg[`IC_PORTB_CHANGE_INT_ENABLE] & interrupt_control_reg[`IC_PORTB_CHANGE_FLAG]) |
        (interrupt_control_reg[`IC_PERIPH_INT_ENABLE] & periph_int_req_i));
      ack_o <= bus_req;
      if (bus_req && !we_i) begin
        case (adr_i)
          `ADDR_CORE_STATUS: dat_o <= core_status_reg;
          `ADDR_INTERRUPT_CONTROL: dat_o <= interrupt_control_reg;
          `ADDR_TIMER_PRESCALE_OPTIONS: dat_o <= timer_prescale_options_reg;
          default: dat_o <= 8'h00;
        endcase
      end
    end
  end
endmodule

// ---- core_status_interrupt_regs_asserts.sv ----
// Port assertions for the core register block
`timescale 1ns/1ps
`include "core_regs_map.vh"
module core_status_interrupt_regs_asserts (
  input wire clk_i,
  input wire rst_i,
  input wire cyc_i,
  input wire stb_i,
  input wire we_i,
  input wire [7:0] adr_i,
  input wire [7:0] dat_i,
  input wire sel_i,
  input wire ack_o,
  input wire [2:0] alu_op_i,
  input wire [7:0] alu_a_i,
  input wire [7:0] alu_b_i,
  input wire [7:0] alu_result_o,
  input wire [6:0] direct_addr_i,
  input wire [7:0] indirect_addr_i,
  input wire [8:0] direct_full_addr_o,
  input wire [8:0] indirect_full_addr_o,
  input wire portb_pullup_enable_o,
  input wire int_request_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  wire tk = cyc_i && stb_i && !ack_o;
  wire wr = tk && we_i && sel_i;
  property p_ack; tk |=> ack_o ##1 !ack_o; endproperty
  a_ack: assert property (p_ack) else $error("ack not one pulse");
  property p_dir; !$past(rst_i) |-> direct_full_addr_o[6:0] == $past(direct_addr_i); endproperty
  a_dir: assert property (p_dir) else $error("direct address wrong");
  property p_ind; !$past(rst_i) |-> indirect_full_addr_o[7:0] == $past(indirect_addr_i); endproperty
  a_ind: assert property (p_ind) else $error("indirect address wrong");
  property p_add; alu_op_i == `OP_ADD |=> alu_result_o == 8'($past(alu_a_i) + $past(alu_b_i)); endproperty
  a_add: assert property (p_add) else $error("add result wrong");
  property p_sub; alu_op_i == `OP_SUB |=> alu_result_o == 8'($past(alu_a_i) - $past(alu_b_i)); endproperty
  a_sub: assert property (p_sub) else $error("sub result wrong");
  property p_rot; alu_op_i == `OP_RLF |=> alu_result_o[7:1] == $past(alu_a_i[6:0]); endproperty
  a_rot: assert property (p_rot) else $error("rotate result wrong");
  property p_pull; wr && adr_i == `ADDR_TIMER_PRESCALE_OPTIONS |-> ##2 portb_pullup_enable_o == !$past(dat_i[7], 2); endproperty
  a_pull: assert property (p_pull) else $error("pull-up enable wrong");
  property p_gie; wr && adr_i == `ADDR_INTERRUPT_CONTROL && !dat_i[7] |-> ##2 !int_request_o; endproperty
  a_gie: assert property (p_gie) else $error("request with global off");
endmodule
bind core_status_interrupt_regs core_status_interrupt_regs_asserts core_status_interrupt_regs_asserts_i (
  .clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .dat_i, .sel_i, .ack_o, .alu_op_i, .alu_a_i, .alu_b_i,
  .alu_result_o, .direct_addr_i, .indirect_addr_i, .direct_full_addr_o, .indirect_full_addr_o,
  .portb_pullup_enable_o, .int_request_o);

// ---- tb_core_status_interrupt_regs.sv ----
// Self-checking bench for the core status and interrupt registers
`timescale 1ns/1ps
`include "core_regs_map.vh"
module tb_core_status_interrupt_regs;
  localparam logic [7:0] st = `ADDR_CORE_STATUS, ic = `ADDR_INTERRUPT_CONTROL, op = `ADDR_TIMER_PRESCALE_OPTIONS;
  logic clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0, sel_i = 0, go = 0, dst = 0;
  logic tovf = 0, ext = 0, preq = 0, wtk = 0, itk = 0, ack_o, t0o, wdo, pue, irq;
  logic [3:0] pb = 4'h0;
  logic [7:0] adr_i = 8'h00, dat_i = 8'h00, dat_o, rd, res, a, b;
  logic [21:0] cmd = 22'h00_0000;
  logic [2:0] aop, ev;
  logic [8:0] dfa, ifa;
  int n_errors = 0, checks_done = 0, nw = 0, nt = 0;
  logic [7:0] rg [5][3] = '{'{st, 8'h40, 8'h58}, '{st, 8'he7, 8'hff}, '{op, 8'h5a, 8'h5a}, '{ic, 8'h38, 8'h38},
    '{8'h55, 8'hff, 8'h00}};
  logic [7:0] al [10][6] = '{'{8'h01, 8'h0f, 8'h01, 8'h00, 8'h10, 8'h1a}, '{8'h01, 8'hff, 8'h01, 8'h00, 8'h00, 8'h1f},
    '{8'h02, 8'h05, 8'h05, 8'h00, 8'h00, 8'h1f}, '{8'h02, 8'h00, 8'h01, 8'h00, 8'hff, 8'h18},
    '{8'h04, 8'h81, 8'h00, 8'h00, 8'h02, 8'h19}, '{8'h05, 8'h02, 8'h00, 8'h00, 8'h81, 8'h18},
    '{8'h03, 8'h00, 8'h00, 8'h00, 8'h00, 8'h1c}, '{8'h03, 8'h01, 8'h00, 8'h02, 8'h01, 8'h10},
    '{8'h03, 8'h01, 8'h00, 8'h01, 8'h01, 8'h00}, '{8'h03, 8'h01, 8'h00, 8'h04, 8'h01, 8'h18}};
  logic [7:0] ir [7][2] = '{'{8'ha7, 8'h01}, '{8'h83, 8'h00}, '{8'h93, 8'h01}, '{8'h8b, 8'h01}, '{8'hc0, 8'h01},
    '{8'h40, 8'h00}, '{8'h80, 8'h00}};
  core_model core_model_i (.clk_i, .go_i(go), .cmd_i(cmd), .op_o(aop), .a_o(a), .b_o(b), .ev_o(ev));
  core_status_interrupt_regs core_status_interrupt_regs_i (
    .clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .dat_i, .sel_i, .dat_o, .ack_o,
    .alu_op_i(aop), .alu_a_i(a), .alu_b_i(b), .alu_dest_status_i(dst), .alu_result_o(res),
    .clear_watchdog_instr_i(ev[2]), .sleep_instr_i(ev[1]), .watchdog_timeout_i(ev[0]),
    .direct_addr_i(7'h55), .indirect_addr_i(8'haa), .direct_full_addr_o(dfa), .indirect_full_addr_o(ifa),
    .timer0_overflow_i(tovf), .ext_int_pin_i(ext), .portb_upper_pins_i(pb), .periph_int_req_i(preq),
    .watchdog_tick_i(wtk), .timer0_clock_pin_i(1'b0), .instr_cycle_tick_i(itk), .timer0_tick_o(t0o),
    .watchdog_tick_o(wdo), .portb_pullup_enable_o(pue), .int_request_o(irq));
  always #20 clk_i = ~clk_i;
  // Tick outputs are unknown until the first reset edge
  always @(posedge clk_i) begin
    if (!rst_i) begin
      nw <= nw + wdo;
      nt <= nt + t0o;
    end
  end
  task conclude;
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task chk(string nm, logic [8:0] s, logic [8:0] e);
    checks_done++;
    if (s !== e) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, e, s);
    end
  endtask
  task wb(logic w, logic [7:0] ad, logic [7:0] d);
    int i;
    i = 0;
    {cyc_i, stb_i, sel_i, we_i, adr_i, dat_i} <= {3'b111, w, ad, d};
    do begin
      @(posedge clk_i);
      i++;
    end while (ack_o !== 1'b1 && i < 20);
    if (ack_o !== 1'b1) begin
      n_errors++;
      conclude();
    end
    rd = dat_o;
    {cyc_i, stb_i} <= 2'b00;
    @(posedge clk_i);
  endtask
  task rc(logic [7:0] ad, logic [7:0] e, string nm);
    wb(0, ad, 8'h00);
    chk(nm, rd, e);
  endtask
  task rst_seq;
    rst_i <= 1;
    repeat (4) @(posedge clk_i);
    rst_i <= 0;
    @(posedge clk_i);
  endtask
  initial begin
    rst_seq();
    foreach (rg[k]) begin
      wb(1, rg[k][0], rg[k][1]);
      rc(rg[k][0], rg[k][2], "register");
    end
    chk("direct", dfa, 9'h1d5);
    chk("indirect", ifa, 9'h1aa);
    $display("register table done");
    rst_seq();
    rc(st, 8'h18, "status reset");
    rc(ic, 8'h00, "intctl reset");
    rc(op, 8'hff, "option reset");
    $display("reset done");
    foreach (al[k]) begin
      cmd <= {al[k][0][2:0], al[k][1], al[k][2], al[k][3][2:0]};
      go <= 1;
      @(posedge clk_i);
      go <= 0;
      repeat (2) @(posedge clk_i);
      chk("alu result", res, al[k][4]);
      wb(0, st, 8'h00);
      chk("status", rd[4:0], al[k][5]);
    end
    cmd <= {3'h3, 8'h01, 8'h00, 3'h0};
    {go, dst} <= 2'b11;
    @(posedge clk_i);
    go <= 0;
    wb(1, st, 8'h04);
    dst <= 0;
    rc(st, 8'h18, "status dest");
    $display("alu done");
    {tovf, ext, preq, pb} <= {3'b111, 4'h8};
    @(posedge clk_i);
    tovf <= 0;
    repeat (6) @(posedge clk_i);
    rc(ic, 8'h07, "flags");
    chk("irq masked", irq, 9'h000);
    foreach (ir[k]) begin
      wb(1, ic, ir[k][0]);
      repeat (2) @(posedge clk_i);
      chk("irq", irq, ir[k][1]);
    end
    rc(ic, 8'h80, "flags cleared");
    $display("interrupt done");
    wb(1, op, 8'h0a);
    @(posedge clk_i);
    chk("pullup", pue, 9'h001);
    repeat (16) begin
      {wtk, itk} <= 2'b11;
      @(posedge clk_i);
      {wtk, itk} <= 2'b00;
      @(posedge clk_i);
    end
    repeat (4) @(posedge clk_i);
    chk("wdt ticks", nw[8:0], 9'h004);
    chk("t0 ticks", nt[8:0], 9'h010);
    $display("prescaler done");
    conclude();
  end
endmodule
